// [pkg/qpx_pkg.sv]
/*
   Shared constants and state types for the two-wire port expander and the master end that drives it.
   Assumes a single 200 MHz system clock on both ends.
*/
package qpx_pkg;

   // ----------------------------------------
   // Clock and serial timing
   // ----------------------------------------
   localparam int         CLK_PERIOD_NS   = 5;
   localparam int         SCL_QUARTER_NS  = 2500;
   localparam int         SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] QTR_CNT_MAX     = 9'(SCL_QUARTER_CYC - 1);

   // ----------------------------------------
   // Widths, counts and reset values
   // ----------------------------------------
   localparam int         PORT_W         = 8;
   localparam int         STRAP_W        = 6;
   localparam int         SYNC_W         = 2 + PORT_W + STRAP_W;
   localparam logic [7:0] PORT_RESET     = 8'hff;
   localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
   localparam logic       ADDR_FIXED_BIT = 1'b1;

   // ----------------------------------------
   // State machines
   // ----------------------------------------
   typedef enum logic [2:0] {
      DS_IDLE  = 3'b000,
      DS_ADDR  = 3'b001,
      DS_AACK  = 3'b010,
      DS_WDATA = 3'b011,
      DS_WACK  = 3'b100,
      DS_RDATA = 3'b101,
      DS_RACK  = 3'b110
   } qpx_dev_state_type;

   typedef enum logic [1:0] {
      MS_IDLE  = 2'b00,
      MS_START = 2'b01,
      MS_BITS  = 2'b10,
      MS_STOP  = 2'b11
   } qpx_mst_state_type;

endpackage : qpx_pkg

// [pkg/qpx_bus_if.sv]
/*
   Two-wire bus between the master end and the expander end.
   Assumes both lines are pulled high when nobody drives them low.
*/
`timescale 1ns/1ps
interface qpx_bus_if;

   // ----------------------------------------
   // Drivers and resolved levels
   // ----------------------------------------
   logic m_scl_out;
   logic m_scl_oe_n;
   logic m_sda_out;
   logic m_sda_oe_n;
   logic d_sda_out;
   logic d_sda_oe_n;
   logic scl;
   logic sda;

   assign scl = m_scl_oe_n | m_scl_out;
   assign sda = (m_sda_oe_n | m_sda_out) & (d_sda_oe_n | d_sda_out);

   modport mst_mp (output m_scl_out, output m_scl_oe_n, output m_sda_out, output m_sda_oe_n,
                   input scl, input sda);
   modport dev_mp (output d_sda_out, output d_sda_oe_n, input scl, input sda);

endinterface : qpx_bus_if

// [src/qpx_expander.sv]
/*
   Expander end: serial slave with eight quasi-bidirectional pins and an open-drain change alert.
   Assumes the bus interface resolves the wires and the pins are pulled high outside.
*/
`timescale 1ns/1ps

// ----------------------------------------
// Three-stage input synchroniser
// ----------------------------------------
module qpx_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // Clock and reset
   input  wire logic         clock_in,
   input  wire logic         rst_in,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         s1_q     <= RST_VAL;
         s2_q     <= RST_VAL;
         s3_q     <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               sync_out[i] <= s3_q[i];
            end
         end
      end
   end
endmodule : qpx_sync

// ----------------------------------------
// Expander
// ----------------------------------------
module qpx_expander (
   // Clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   // Serial bus
   qpx_bus_if.dev_mp       bus,
   // Address straps
   input  wire logic [5:0] addr_strap_pins_in,
   // Port pins
   input  wire logic [3:0] port_pins_low_in,
   input  wire logic [3:0] port_pins_high_in,
   output logic      [3:0] port_pins_low_out,
   output logic      [3:0] port_pins_low_oe_n_out,
   output logic      [3:0] port_pins_high_out,
   output logic      [3:0] port_pins_high_oe_n_out,
   output logic      [7:0] port_strong_pu_out,
   // Change alert
   output logic            alert_out,
   output logic            alert_oe_n_out
);
   qpx_pkg::qpx_dev_state_type state_q;
   logic [qpx_pkg::SYNC_W-1:0] sync_w;
   logic       scl_s;
   logic       sda_s;
   logic [7:0] pins_s;
   logic [5:0] strap_s;
   logic       scl_prev_q;
   logic       sda_prev_q;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic       rw_q;
   logic       mack_q;
   logic [7:0] latch_q;
   logic [7:0] ref_q;
   logic [7:0] diff;
   logic       wr_commit;
   logic       rd_clear;

   // ----------------------------------------
   // Input capture and bus conditions
   // ----------------------------------------
   qpx_sync #(
      .W       (qpx_pkg::SYNC_W),
      .RST_VAL ({qpx_pkg::SYNC_W{1'b1}})
   ) u_sync (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .async_in ({bus.scl, bus.sda, port_pins_high_in, port_pins_low_in, addr_strap_pins_in}),
      .sync_out (sync_w)
   );

   assign scl_s   = sync_w[qpx_pkg::SYNC_W-1];
   assign sda_s   = sync_w[qpx_pkg::SYNC_W-2];
   assign pins_s  = sync_w[qpx_pkg::STRAP_W +: qpx_pkg::PORT_W];
   assign strap_s = sync_w[qpx_pkg::STRAP_W-1:0];

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_prev_q;
   assign scl_fall  = ~scl_s & scl_prev_q;
   assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   assign wr_commit = (state_q == qpx_pkg::DS_WDATA) & scl_fall & (cnt_q == qpx_pkg::BITS_PER_BYTE)
                      & ~start_det & ~stop_det;
   assign rd_clear  = (state_q == qpx_pkg::DS_RACK) & scl_rise & ~start_det & ~stop_det;

   // ----------------------------------------
   // Serial slave
   // ----------------------------------------
   // A start or stop aborts any byte in progress; a stop inside the first nine clocks is not supported.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_q        <= qpx_pkg::DS_IDLE;
         cnt_q          <= 4'h0;
         shift_q        <= 8'h00;
         rw_q           <= 1'b0;
         mack_q         <= 1'b0;
         bus.d_sda_oe_n <= 1'b1;
      end else if (start_det) begin
         state_q        <= qpx_pkg::DS_ADDR;
         cnt_q          <= 4'h0;
         bus.d_sda_oe_n <= 1'b1;
      end else if (stop_det) begin
         state_q        <= qpx_pkg::DS_IDLE;
         bus.d_sda_oe_n <= 1'b1;
      end else begin
         unique case (state_q)
            qpx_pkg::DS_IDLE: begin
               bus.d_sda_oe_n <= 1'b1;
            end
            qpx_pkg::DS_ADDR: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_s};
                  cnt_q   <= cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == qpx_pkg::BITS_PER_BYTE) begin
                  cnt_q <= 4'h0;
                  if (shift_q[7:1] == {qpx_pkg::ADDR_FIXED_BIT, strap_s}) begin
                     state_q        <= qpx_pkg::DS_AACK;
                     rw_q           <= shift_q[0];
                     bus.d_sda_oe_n <= 1'b0;
                  end else begin
                     state_q <= qpx_pkg::DS_IDLE;
                  end
               end
            end
            qpx_pkg::DS_AACK, qpx_pkg::DS_RACK: begin
               if (scl_rise) begin
                  mack_q <= ~sda_s;
               end else if (scl_fall) begin
                  if (state_q == qpx_pkg::DS_AACK && !rw_q) begin
                     state_q        <= qpx_pkg::DS_WDATA;
                     bus.d_sda_oe_n <= 1'b1;
                  end else if (state_q == qpx_pkg::DS_AACK || mack_q) begin
                     state_q        <= qpx_pkg::DS_RDATA;
                     shift_q        <= pins_s;
                     bus.d_sda_oe_n <= pins_s[7];
                     cnt_q          <= 4'h1;
                  end else begin
                     state_q        <= qpx_pkg::DS_IDLE;
                     bus.d_sda_oe_n <= 1'b1;
                  end
               end
            end
            qpx_pkg::DS_WDATA: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_s};
                  cnt_q   <= cnt_q + 4'h1;
               end else if (wr_commit) begin
                  state_q        <= qpx_pkg::DS_WACK;
                  cnt_q          <= 4'h0;
                  bus.d_sda_oe_n <= 1'b0;
               end
            end
            qpx_pkg::DS_WACK: begin
               if (scl_fall) begin
                  state_q        <= qpx_pkg::DS_WDATA;
                  bus.d_sda_oe_n <= 1'b1;
               end
            end
            qpx_pkg::DS_RDATA: begin
               if (scl_fall) begin
                  if (cnt_q == qpx_pkg::BITS_PER_BYTE) begin
                     state_q        <= qpx_pkg::DS_RACK;
                     bus.d_sda_oe_n <= 1'b1;
                  end else begin
                     bus.d_sda_oe_n <= shift_q[6];
                     shift_q        <= {shift_q[6:0], 1'b0};
                     cnt_q          <= cnt_q + 4'h1;
                  end
               end
            end
            default: begin
               state_q        <= qpx_pkg::DS_IDLE;
               bus.d_sda_oe_n <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         bus.d_sda_out <= 1'b0;
      end else begin
         bus.d_sda_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // Port latch and pull-ups
   // ----------------------------------------
   // A pin latched low is actively pulled down; a pin latched high gets the strong pull-up from the write commit to the next clock fall, then only the weak source.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         latch_q            <= qpx_pkg::PORT_RESET;
         port_strong_pu_out <= 8'h00;
      end else if (wr_commit) begin
         latch_q            <= shift_q;
         port_strong_pu_out <= shift_q;
      end else if (scl_fall) begin
         port_strong_pu_out <= 8'h00;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         port_pins_low_out       <= 4'h0;
         port_pins_high_out      <= 4'h0;
         port_pins_low_oe_n_out  <= qpx_pkg::PORT_RESET[3:0];
         port_pins_high_oe_n_out <= qpx_pkg::PORT_RESET[7:4];
      end else begin
         port_pins_low_out       <= 4'h0;
         port_pins_high_out      <= 4'h0;
         port_pins_low_oe_n_out  <= latch_q[3:0];
         port_pins_high_oe_n_out <= latch_q[7:4];
      end
   end

   // ----------------------------------------
   // Change alert
   // ----------------------------------------
   // Only pins latched high can act as inputs, so pins driven low never raise the alert.
   assign diff = (pins_s ^ ref_q) & latch_q;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         alert_oe_n_out <= 1'b1;
         ref_q          <= qpx_pkg::PORT_RESET;
      end else if (wr_commit || rd_clear) begin
         alert_oe_n_out <= 1'b1;
         ref_q          <= pins_s;
      end else if (scl_rise && |diff) begin
         alert_oe_n_out <= 1'b0;
      end else if (!alert_oe_n_out && !(|diff)) begin
         alert_oe_n_out <= 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         alert_out <= 1'b0;
      end else begin
         alert_out <= 1'b0;
      end
   end

endmodule : qpx_expander

// [src/qpx_master.sv]
/*
   Master end: issues one port write or one single-byte port read per request.
   Assumes qpx_sync is compiled from the expander file and no clock stretching occurs.
*/
`timescale 1ns/1ps
module qpx_master (
   // Clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   // Serial bus
   qpx_bus_if.mst_mp       bus,
   // Request
   input  wire logic       go_in,
   input  wire logic       rw_in,
   input  wire logic [6:0] addr_in,
   input  wire logic [7:0] wdata_in,
   // Answer
   output logic            busy_out,
   output logic            done_out,
   output logic            nack_out,
   output logic      [7:0] rdata_out
);
   qpx_pkg::qpx_mst_state_type state_q;
   logic       sda_s;
   logic [8:0] qcnt_q;
   logic       tick;
   logic [1:0] ph_q;
   logic [3:0] bitn_q;
   logic       byte_q;
   logic       rw_q;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic       ack_q;
   logic       rd_byte;

   qpx_sync #(
      .W       (1),
      .RST_VAL (1'b1)
   ) u_sync (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .async_in (bus.sda),
      .sync_out (sda_s)
   );

   // ----------------------------------------
   // Quarter-period divider
   // ----------------------------------------
   assign tick    = (qcnt_q == qpx_pkg::QTR_CNT_MAX);
   assign rd_byte = byte_q & rw_q;

   always_ff @(posedge clock_in) begin
      if (rst_in || state_q == qpx_pkg::MS_IDLE || tick) begin
         qcnt_q <= 9'h000;
      end else begin
         qcnt_q <= qcnt_q + 9'h001;
      end
   end

   // ----------------------------------------
   // Transfer sequencer
   // ----------------------------------------
   // Idle bus rests with both lines released, so a new start is only issued from idle.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_q        <= qpx_pkg::MS_IDLE;
         ph_q           <= 2'h0;
         bitn_q         <= 4'h0;
         byte_q         <= 1'b0;
         rw_q           <= 1'b0;
         tx_q           <= 8'h00;
         rx_q           <= 8'h00;
         ack_q          <= 1'b0;
         busy_out       <= 1'b0;
         done_out       <= 1'b0;
         nack_out       <= 1'b0;
         rdata_out      <= 8'h00;
         bus.m_scl_oe_n <= 1'b1;
         bus.m_sda_oe_n <= 1'b1;
      end else begin
         done_out <= 1'b0;
         unique case (state_q)
            qpx_pkg::MS_IDLE: begin
               if (go_in) begin
                  state_q        <= qpx_pkg::MS_START;
                  rw_q           <= rw_in;
                  tx_q           <= {addr_in, rw_in};
                  busy_out       <= 1'b1;
                  nack_out       <= 1'b0;
                  bus.m_sda_oe_n <= 1'b0;
               end
            end
            qpx_pkg::MS_START: begin
               if (tick) begin
                  state_q        <= qpx_pkg::MS_BITS;
                  bus.m_scl_oe_n <= 1'b0;
                  ph_q           <= 2'h0;
                  bitn_q         <= 4'h0;
                  byte_q         <= 1'b0;
               end
            end
            qpx_pkg::MS_BITS: begin
               if (tick) begin
                  ph_q <= ph_q + 2'h1;
                  unique case (ph_q)
                     2'h0: bus.m_sda_oe_n <= (bitn_q == qpx_pkg::BITS_PER_BYTE) | rd_byte | tx_q[7];
                     2'h1: bus.m_scl_oe_n <= 1'b1;
                     2'h2: begin
                        if (bitn_q == qpx_pkg::BITS_PER_BYTE) begin
                           ack_q <= ~sda_s;
                        end else begin
                           rx_q <= {rx_q[6:0], sda_s};
                        end
                     end
                     2'h3: begin
                        bus.m_scl_oe_n <= 1'b0;
                        tx_q           <= {tx_q[6:0], 1'b0};
                        if (bitn_q != qpx_pkg::BITS_PER_BYTE) begin
                           bitn_q <= bitn_q + 4'h1;
                        end else if (!byte_q && ack_q) begin
                           byte_q <= 1'b1;
                           bitn_q <= 4'h0;
                           tx_q   <= wdata_in;
                        end else begin
                           state_q  <= qpx_pkg::MS_STOP;
                           nack_out <= ~byte_q | (~rw_q & ~ack_q);
                        end
                     end
                     default: ;
                  endcase
               end
            end
            qpx_pkg::MS_STOP: begin
               if (tick) begin
                  ph_q <= ph_q + 2'h1;
                  unique case (ph_q)
                     2'h0: bus.m_sda_oe_n <= 1'b0;
                     2'h1: bus.m_scl_oe_n <= 1'b1;
                     2'h2: bus.m_sda_oe_n <= 1'b1;
                     2'h3: begin
                        state_q   <= qpx_pkg::MS_IDLE;
                        busy_out  <= 1'b0;
                        done_out  <= 1'b1;
                        rdata_out <= rx_q;
                     end
                     default: ;
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         bus.m_scl_out <= 1'b0;
         bus.m_sda_out <= 1'b0;
      end else begin
         bus.m_scl_out <= 1'b0;
         bus.m_sda_out <= 1'b0;
      end
   end

endmodule : qpx_master

// [tb/qpx_bus_properties.sv]
/*
   Wire-level checks on the two-wire bus between master and expander.
   Assumes one clock domain and the resolved lines of qpx_bus_if.
*/
`timescale 1ns/1ps
module qpx_bus_properties (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Bus lines
   input wire logic scl,
   input wire logic sda,
   input wire logic d_sda_oe_n
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   // ----------------------------------------
   // Clock rises since the last start
   // ----------------------------------------
   logic [7:0] rises_q;
   always_ff @(posedge clock_in) begin
      if (rst_in || (scl && $fell(sda))) begin
         rises_q <= 8'h00;
      end else if ($rose(scl) && rises_q != 8'hff) begin
         rises_q <= rises_q + 8'h01;
      end
   end
   sequence s_start; scl && $fell(sda); endsequence
   sequence s_stop; scl && $rose(sda); endsequence
   property p_idle; $fell(rst_in) |-> scl && sda; endproperty
   a_idle: assert property (p_idle) else $error("bus not idle high");
   property p_dev_hold; scl && $past(scl) |-> $stable(d_sda_oe_n); endproperty
   a_dev_hold: assert property (p_dev_hold) else $error("data moved in clock high");
   property p_dev_edge; $changed(d_sda_oe_n) |-> !scl && $past(scl, 12); endproperty
   a_dev_edge: assert property (p_dev_edge) else $error("data not moved after fall");
   property p_start_clk; s_start |-> ##[400:600] $fell(scl); endproperty
   a_start_clk: assert property (p_start_clk) else $error("no clock after start");
   property p_nine; s_stop |-> rises_q >= 8'h09; endproperty
   a_nine: assert property (p_nine) else $error("stop too early");
   property p_scl_high; $rose(scl) |-> scl[*8]; endproperty
   a_scl_high: assert property (p_scl_high) else $error("short clock high");
   property p_scl_low; $fell(scl) |-> (!scl)[*8]; endproperty
   a_scl_low: assert property (p_scl_low) else $error("short clock low");
   property p_ack_low; $rose(scl) && !d_sda_oe_n |-> (!sda)[*8]; endproperty
   a_ack_low: assert property (p_ack_low) else $error("ack not low");
   property p_stop_free; s_stop |=> d_sda_oe_n[*8]; endproperty
   a_stop_free: assert property (p_stop_free) else $error("data held after stop");
endmodule : qpx_bus_properties

// [tb/i2c_quasi_bidir_port_expander_tb.sv]
/*
   Testbench joining master and expander: write, foreign write with pin change, read.
   Assumes the package timing (500 cycles a quarter), so only three frames fit the run.
*/
`timescale 1ns/1ps
module i2c_quasi_bidir_port_expander_tb;
   logic       clock_in = 1'b0;
   logic       rst_in   = 1'b1;
   logic       go_q     = 1'b0;
   logic       rw_q     = 1'b0;
   logic [6:0] addr_q   = 7'h00;
   logic [7:0] wdata_q  = 8'h00;
   logic [5:0] strap_q  = 6'h00;
   logic [7:0] ext_q    = 8'hff;
   logic [7:0] pu_seen  = 8'h00;
   logic [3:0] lo_oe_n, hi_oe_n;
   logic [7:0] pu, rdata;
   logic       busy, done, nack, alert_oe_n;
   logic [3:0] lo_drv, hi_drv;
   logic       alert_drv;
   int         error_cnt = 0;
   int         checks    = 0;
   int         latch_m, own_m, wd_m;
   wire [7:0]  pin_lvl = ext_q & {hi_oe_n, lo_oe_n};
   always #2.5 clock_in = ~clock_in;
   qpx_bus_if qpx_bus_if_inst ();
   qpx_master qpx_master_inst (.clock_in(clock_in), .rst_in(rst_in), .bus(qpx_bus_if_inst.mst_mp),
      .go_in(go_q), .rw_in(rw_q), .addr_in(addr_q), .wdata_in(wdata_q), .busy_out(busy),
      .done_out(done), .nack_out(nack), .rdata_out(rdata));
   qpx_expander qpx_expander_inst (.clock_in(clock_in), .rst_in(rst_in), .bus(qpx_bus_if_inst.dev_mp),
      .addr_strap_pins_in(strap_q), .port_pins_low_in(pin_lvl[3:0]), .port_pins_high_in(pin_lvl[7:4]),
      .port_pins_low_out(lo_drv), .port_pins_low_oe_n_out(lo_oe_n), .port_pins_high_out(hi_drv),
      .port_pins_high_oe_n_out(hi_oe_n), .port_strong_pu_out(pu), .alert_out(alert_drv),
      .alert_oe_n_out(alert_oe_n));
   qpx_bus_properties qpx_bus_properties_inst (.clock_in(clock_in), .rst_in(rst_in),
      .scl(qpx_bus_if_inst.scl), .sda(qpx_bus_if_inst.sda), .d_sda_oe_n(qpx_bus_if_inst.d_sda_oe_n));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done
   // The pin change is placed early in the frame so that later clock rises capture it.
   task automatic txn(input logic rw, input logic [6:0] addr, input logic [7:0] wd, input int pin_at);
      int n;
      n = 0;
      @(posedge clock_in); #1;
      rw_q = rw; addr_q = addr; wdata_q = wd; go_q = 1'b1; pu_seen = 8'h00;
      @(posedge clock_in); #1;
      go_q = 1'b0;
      chk("busy", 8'h01, {7'h00, busy});
      while (done !== 1'b1 && n < 45000) begin
         @(posedge clock_in); #1;
         n++;
         pu_seen |= pu;
         if (n == pin_at) ext_q[4] = 1'b0;
      end
      chk("done", 8'h01, {7'h00, done});
      chk("busy", 8'h00, {7'h00, busy});
   endtask : txn
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h0c1a));
      strap_q = 6'($urandom);
      wd_m = {4'hf, 4'($urandom)};
      own_m = {1'b1, strap_q};
      repeat (16) @(posedge clock_in);
      #1 rst_in = 1'b0;
      chk("oe_n", 8'hff, {hi_oe_n, lo_oe_n});
      chk("pu", 8'h00, pu);
      chk("alert", 8'h01, {7'h00, alert_oe_n});
      txn(1'b0, 7'(own_m), 8'(wd_m), 0);
      latch_m = wd_m;
      chk("nack", 8'h00, {7'h00, nack});
      chk("oe_n", 8'(latch_m), {hi_oe_n, lo_oe_n});
      chk("pu_seen", 8'(wd_m), pu_seen);
      chk("pu", 8'h00, pu);
      txn(1'b0, 7'(own_m ^ 1), 8'(~wd_m), 2000);
      chk("nack", 8'h01, {7'h00, nack});
      chk("oe_n", 8'(latch_m), {hi_oe_n, lo_oe_n});
      chk("alert", 8'h00, {7'h00, alert_oe_n});
      ext_q[4] = 1'b1;
      repeat (10) @(posedge clock_in);
      chk("alert", 8'h01, {7'h00, alert_oe_n});
      ext_q[4] = 1'b0;
      repeat (10) @(posedge clock_in);
      chk("alert", 8'h01, {7'h00, alert_oe_n});
      txn(1'b1, 7'(own_m), 8'h00, 0);
      chk("nack", 8'h00, {7'h00, nack});
      chk("rdata", 8'(latch_m) & ext_q, rdata);
      chk("alert", 8'h01, {7'h00, alert_oe_n});
      chk("drive", 8'h00, {hi_drv, lo_drv});
      chk("alert_drv", 8'h00, {7'h00, alert_drv});
      test_done();
   end
   initial begin
      #(5 * 99000);
      error_cnt++;
      test_done();
   end
endmodule : i2c_quasi_bidir_port_expander_tb
